// ---- pkg/smcs_defs.vh ----
// Constants for the stop mode clock sequencer.
// How it works
// RULE1: In wait mode with monitor, self-clock and its interrupt enabled, a clock failure powers regulator and PLL, enters self-clock mode, starts a quality check, sets the flag and raises a wake-up interrupt.
// RULE2: The oscillator is off in stop mode unless pseudo-stop is selected.
// RULE3: During stop all counters and dividers hold their value and resume from it.
// RULE4: With the watchdog or periodic tick pseudo-stop enable set, that counter keeps running in pseudo-stop.
// RULE5: Stop entry also sends power-saving requests to other units such as the regulator, which wait mode does not.
// RULE6: On a stop request the PLL select is cleared, then the PLL, then the core clock, then the system clocks are switched off, and stop is active.
// In the code the PLL select is cleared in the same cycle as the PLL is switched off.
// RULE7: Pseudo-stop entered in self-clock mode keeps checking clock quality until success with PLL and regulator on.
// RULE8: Full stop entered in self-clock mode aborts a running check and starts a fresh full check on leaving stop.
// RULE9: An external reset in pseudo-stop restores all configuration bits and starts the reset sequence with the normal vector.
// RULE10: With monitor on and self-clock off, oscillator loss in pseudo-stop gives a clock-monitor reset with its own vector.
// RULE11: With self-clock and its interrupt on, oscillator loss in pseudo-stop raises the interrupt, enters self-clock mode, starts the checker and wakes the processor.
// RULE12: With the self-clock interrupt off, oscillator loss in pseudo-stop sets the flag but does not wake.
// RULE13: Any other enabled interrupt ends pseudo-stop at once.
// RULE14: After stop the PLL select stays cleared until software sets it again.
// RULE15: With the monitor off, clock failure in pseudo-stop is not detected and has no effect.
// RULE16: A quality check passes only after a fixed count of oscillator cycles without failure, then self-clock mode, PLL and regulator are released.
// RULE17: The self-clock flag stays set until software clears it.
`ifndef SMCS_DEFS_VH
`define SMCS_DEFS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SMCS_CTRL_ADDR    12'h000
`define SMCS_STAT_ADDR    12'h004
`define SMCS_IRQ_ST_ADDR  12'h008
`define SMCS_IRQ_EN_ADDR  12'h00C
`define SMCS_IRQ_CLR_ADDR 12'h010
`define SMCS_CNT_ADDR     12'h014
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SMCS_C_CME   0
`define SMCS_C_SELF_CLOCK_MODE_ENABLE  1
`define SMCS_C_SELF_CLOCK_IRQ_ENABLE 2
`define SMCS_C_PSEUDO_STOP_SELECT  3
`define SMCS_C_WDPS  4
`define SMCS_C_RTPS  5
`define SMCS_C_PLLS  6
`define SMCS_C_FLAG  7
`define SMCS_CTRL_RST 8'h02
// ----------------------------------------------------------------
// Event bits
// ----------------------------------------------------------------
`define SMCS_EV_STOP  0
`define SMCS_EV_WAKE  1
`define SMCS_EV_SCM   2
`define SMCS_EV_CMRST 3
`define SMCS_EV_QOK   4
`define SMCS_EV_W     5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMCS_QC_CYCLES 4096
`endif

// ---- design/smcs_top.v ----
// Stop mode clock sequencer with APB register access.
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "smcs_defs.vh"
module smcs_top #(
  parameter QC_CYCLES = `SMCS_QC_CYCLES,
  parameter CNT_W     = 16
)(
  input  wire        CLOCK,          // System clock, 20 MHz.
  input  wire        RSTN,           // Synchronous reset, active low.
  input  wire        PSEL,           // APB select.
  input  wire        PENABLE,        // APB access phase.
  input  wire        PWRITE,         // APB direction.
  input  wire [11:0] PADDR,          // APB byte address.
  input  wire [31:0] PWDATA,         // APB write data.
  output wire [31:0] PRDATA,         // APB read data.
  output wire        PREADY,         // APB ready.
  output wire        PSLVERR,        // APB error on unmapped address.
  input  wire        STOP_REQ,       // Core requests stop.
  input  wire        WAIT_MODE,      // Core is in wait mode.
  input  wire        EXT_RESET_N,    // External reset pin, active low.
  input  wire        OSC_FAIL,       // Clock monitor sees oscillator loss.
  input  wire        OTHER_IRQ,      // Other enabled wake-up interrupt.
  output reg         OSC_EN,         // Oscillator enable.
  output reg         PLL_EN,         // PLL enable.
  output reg         VOLTAGE_REGULATOR_EN,        // Regulator full-power enable.
  output reg         CORE_CLK_EN,    // Core clock enable.
  output reg         SYS_CLK_EN,     // System clock enable.
  output reg         PWR_SAVE_REQ,   // Power-saving request to other units.
  output reg         SELF_CLOCK,     // Self-clock mode active.
  output reg         STOP_ACTIVE,    // Stop mode active.
  output reg         WAKE,           // Wake pulse to the core.
  output reg         SCM_IRQ,        // Self-clock wake-up interrupt pulse.
  output reg         RESET_REQ,      // Reset generator start pulse.
  output reg         CM_VECTOR,      // Reset came from the clock monitor.
  output wire        IRQ             // Level interrupt.
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [5:0] S_RUN  = 6'h01;
  localparam [5:0] S_PLLS = 6'h02;
  localparam [5:0] S_PLL  = 6'h04;
  localparam [5:0] S_CORE = 6'h08;
  localparam [5:0] S_SYS  = 6'h10;
  localparam [5:0] S_STOP = 6'h20;

  reg  [5:0]       st_q;
  reg  [5:0]       st_d;
  reg  [7:0]       ctrl_q;
  reg  [`SMCS_EV_W-1:0] ev_q;
  reg  [`SMCS_EV_W-1:0] en_q;
  reg  [12:0]      qc_q;
  reg              qc_run_q;
  reg              qc_restart_q;
  wire [CNT_W-1:0] wd_q;
  wire [CNT_W-1:0] rt_q;
  wire [CNT_W-1:0] div_q;
  wire [2:0]       cnt_run;
  wire [CNT_W-1:0] cnt_val [0:2];
  reg  [31:0]      rdata_q;
  reg              rvalid_q;
  reg  [`SMCS_EV_W-1:0] ev_set;
  reg              wake_now;
  reg              scm_hit;
  reg              cm_rst;

  wire wr  = PSEL & PENABLE & PWRITE;
  // Reads take one wait state: the word is captured first, then offered with ready.
  wire rd  = PSEL & PENABLE & ~PWRITE & ~rvalid_q;
  wire wr_ctrl = wr & (PADDR == `SMCS_CTRL_ADDR);
  wire wr_en   = wr & (PADDR == `SMCS_IRQ_EN_ADDR);
  wire wr_clr  = wr & (PADDR == `SMCS_IRQ_CLR_ADDR);
  wire clock_monitor_enable   = ctrl_q[`SMCS_C_CME];
  wire self_clock_mode_enable  = ctrl_q[`SMCS_C_SELF_CLOCK_MODE_ENABLE];
  wire self_clock_irq_enable = ctrl_q[`SMCS_C_SELF_CLOCK_IRQ_ENABLE];
  wire pseudo_stop_select  = ctrl_q[`SMCS_C_PSEUDO_STOP_SELECT];
  wire pstop = (st_q == S_STOP) & pseudo_stop_select;
  wire fstop = (st_q == S_STOP) & ~pseudo_stop_select;
  wire ext_rst = ~EXT_RESET_N;
  // Monitor only watches while the oscillator should be running.
  wire mon_fail = clock_monitor_enable & OSC_FAIL & ~fstop; // RULE15
  wire qc_done = qc_run_q & (qc_q == QC_CYCLES[12:0] - 13'h0001);

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `SMCS_CTRL_ADDR) | (a == `SMCS_STAT_ADDR) |
               (a == `SMCS_IRQ_ST_ADDR) | (a == `SMCS_IRQ_EN_ADDR) |
               (a == `SMCS_IRQ_CLR_ADDR) | (a == `SMCS_CNT_ADDR);
    end
  endfunction

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  assign PREADY  = PSEL & PENABLE & (PWRITE | rvalid_q);
  assign PSLVERR = PSEL & PENABLE & (PWRITE | rvalid_q) & ~mapped(PADDR);
  assign PRDATA  = rdata_q;
  assign IRQ     = |(ev_q & en_q);

  // Status word, one field a line so its layout is easy to hold against software.
  wire [31:0] stat_word = {
    19'h00000,
    qc_run_q,
    CM_VECTOR,
    st_q,
    SELF_CLOCK,
    STOP_ACTIVE,
    PLL_EN,
    VOLTAGE_REGULATOR_EN,
    OSC_EN
  };

  // ----------------------------------------------------------------
  // Entry sequence and wake decisions
  // ----------------------------------------------------------------
  always @*
  begin
    st_d     = st_q;
    wake_now = 1'b0;
    scm_hit  = 1'b0;
    cm_rst   = 1'b0;
    case (st_q)
      S_RUN:
      begin
        if (STOP_REQ)
          st_d = S_PLLS; // RULE6
      end
      S_PLLS:
        st_d = S_PLL;
      S_PLL:
        st_d = S_CORE;
      S_CORE:
        st_d = S_SYS;
      S_SYS:
        st_d = S_STOP;
      S_STOP:
      begin
        if (mon_fail & ~SELF_CLOCK & ~self_clock_mode_enable)
        begin
          cm_rst = 1'b1; // RULE10
        end
        else if (mon_fail & ~SELF_CLOCK & self_clock_mode_enable)
        begin
          scm_hit = 1'b1;
        end
        // With the self-clock interrupt masked the flag is set but the core sleeps on.
        if (OTHER_IRQ | (scm_hit & self_clock_irq_enable)) // RULE11 RULE12 RULE13
        begin
          wake_now = 1'b1;
        end
        if (wake_now | cm_rst)
        begin
          st_d = S_RUN;
        end
      end
      default: st_d = S_RUN;
    endcase
    // Wait mode failure behaves like pseudo-stop failure.
    if (st_q == S_RUN && WAIT_MODE && mon_fail && !SELF_CLOCK && self_clock_mode_enable)
    begin
      scm_hit  = 1'b1; // RULE1
      wake_now = self_clock_irq_enable;
    end
    // A monitor failure in run or wait with self-clock off is a reset as well.
    if (st_q == S_RUN && mon_fail && !SELF_CLOCK && !self_clock_mode_enable)
    begin
      cm_rst = 1'b1; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Clock gating, self-clock mode and quality checker
  // ----------------------------------------------------------------
  always @(posedge CLOCK)
  begin
    if (!RSTN || ext_rst)
    begin
      st_q         <= S_RUN; // RULE9
      OSC_EN       <= 1'b1;
      PLL_EN       <= 1'b0;
      VOLTAGE_REGULATOR_EN      <= 1'b1;
      CORE_CLK_EN  <= 1'b1;
      SYS_CLK_EN   <= 1'b1;
      PWR_SAVE_REQ <= 1'b0;
      SELF_CLOCK   <= 1'b0;
      STOP_ACTIVE  <= 1'b0;
      qc_q         <= 13'h0000;
      qc_run_q     <= 1'b0;
      qc_restart_q <= 1'b0;
    end
    else
    begin
      st_q <= cm_rst ? S_RUN : st_d;
      case (st_d)
        S_PLL:
          PLL_EN <= SELF_CLOCK & pseudo_stop_select; // RULE6 RULE7
        S_CORE:
          CORE_CLK_EN <= 1'b0;
        S_SYS:
          SYS_CLK_EN <= 1'b0;
        default: ;
      endcase
      if (st_d == S_STOP && st_q == S_SYS)
      begin
        STOP_ACTIVE  <= 1'b1;
        PWR_SAVE_REQ <= 1'b1; // RULE5
        OSC_EN       <= pseudo_stop_select; // RULE2
        VOLTAGE_REGULATOR_EN      <= SELF_CLOCK & pseudo_stop_select; // RULE7
        if (!pseudo_stop_select && qc_run_q)
        begin
          qc_run_q     <= 1'b0; // RULE8
          qc_restart_q <= 1'b1;
        end
      end
      if (st_q == S_STOP && st_d == S_RUN)
      begin
        STOP_ACTIVE  <= 1'b0;
        PWR_SAVE_REQ <= 1'b0;
        OSC_EN       <= 1'b1;
        CORE_CLK_EN  <= 1'b1;
        SYS_CLK_EN   <= 1'b1;
        if (qc_restart_q)
        begin
          qc_restart_q <= 1'b0; // RULE8
          qc_run_q     <= 1'b1;
          qc_q         <= 13'h0000;
        end
      end
      if (scm_hit)
      begin
        SELF_CLOCK <= 1'b1; // RULE1 RULE11
        PLL_EN     <= 1'b1;
        VOLTAGE_REGULATOR_EN    <= 1'b1;
        qc_run_q   <= 1'b1;
        qc_q       <= 13'h0000;
      end
      else if (qc_run_q && !fstop)
      begin
        if (OSC_FAIL)
          qc_q <= 13'h0000; // RULE16
        else if (qc_done)
        begin
          qc_run_q   <= 1'b0; // RULE16
          SELF_CLOCK <= 1'b0;
          PLL_EN     <= 1'b0;
          if (st_q == S_STOP)
            VOLTAGE_REGULATOR_EN <= 1'b0;
        end
        else
          qc_q <= qc_q + 13'h0001; // RULE7
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters: frozen in stop, optionally running in pseudo-stop
  // ----------------------------------------------------------------
  assign cnt_run[0] = ~STOP_ACTIVE; // RULE3
  assign cnt_run[1] = ~STOP_ACTIVE | (pstop & ctrl_q[`SMCS_C_WDPS]); // RULE4
  assign cnt_run[2] = ~STOP_ACTIVE | (pstop & ctrl_q[`SMCS_C_RTPS]); // RULE4

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_cnt
      reg [CNT_W-1:0] cnt_q;
      // Stop holds the count instead of clearing it, so timing resumes where it left off.
      always @(posedge CLOCK)
      begin
        if (!RSTN)
          cnt_q <= {CNT_W{1'b0}};
        else if (cnt_run[gi])
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE3 RULE4
      end
      assign cnt_val[gi] = cnt_q;
    end
  endgenerate

  assign div_q = cnt_val[0];
  assign wd_q  = cnt_val[1];
  assign rt_q  = cnt_val[2];

  // ----------------------------------------------------------------
  // Pulses to core and reset generator, and the held clock-monitor vector flag
  // ----------------------------------------------------------------
  always @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      WAKE      <= 1'b0;
      SCM_IRQ   <= 1'b0;
      RESET_REQ <= 1'b0;
      CM_VECTOR <= 1'b0;
    end
    else
    begin
      WAKE      <= wake_now & ~ext_rst;
      SCM_IRQ   <= scm_hit & self_clock_irq_enable & ~ext_rst; // RULE11
      RESET_REQ <= ext_rst | cm_rst; // RULE9 RULE10
      if (ext_rst)
        CM_VECTOR <= 1'b0;
      else if (cm_rst)
        CM_VECTOR <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Event set sources
  // ----------------------------------------------------------------
  always @*
  begin
    ev_set = {`SMCS_EV_W{1'b0}};
    ev_set[`SMCS_EV_STOP]  = (st_q == S_SYS);
    ev_set[`SMCS_EV_WAKE]  = wake_now;
    ev_set[`SMCS_EV_SCM]   = scm_hit;
    ev_set[`SMCS_EV_CMRST] = cm_rst;
    ev_set[`SMCS_EV_QOK]   = qc_done & ~OSC_FAIL & ~scm_hit;
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  always @(posedge CLOCK)
  begin
    if (!RSTN || ext_rst)
    begin
      ctrl_q  <= `SMCS_CTRL_RST; // RULE9
      ev_q    <= {`SMCS_EV_W{1'b0}};
      en_q    <= {`SMCS_EV_W{1'b0}};
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= rd;
      if (wr_ctrl)
        ctrl_q[6:0] <= PWDATA[6:0];
      if (st_d == S_PLL && st_q == S_PLLS)
        ctrl_q[`SMCS_C_PLLS] <= 1'b0; // RULE6 RULE14
      // Hardware set wins over a software clear in the same cycle.
      if (scm_hit)
        ctrl_q[`SMCS_C_FLAG] <= 1'b1; // RULE12 RULE17
      else if (wr_ctrl && !PWDATA[`SMCS_C_FLAG])
        ctrl_q[`SMCS_C_FLAG] <= 1'b0; // RULE17
      // A clock-monitor reset restores the configuration just as a pin reset does.
      if (cm_rst)
        ctrl_q <= `SMCS_CTRL_RST; // RULE10
      if (wr_en)
        en_q <= PWDATA[`SMCS_EV_W-1:0];
      if (wr_clr)
        ev_q <= (ev_q & ~PWDATA[`SMCS_EV_W-1:0]) | ev_set;
      else
        ev_q <= ev_q | ev_set;
      if (rd)
      begin
        case (PADDR)
          `SMCS_CTRL_ADDR:
            rdata_q <= {24'h000000, ctrl_q};
          `SMCS_STAT_ADDR:
            rdata_q <= stat_word;
          `SMCS_IRQ_ST_ADDR:
            rdata_q <= {{(32-`SMCS_EV_W){1'b0}}, ev_q};
          `SMCS_IRQ_EN_ADDR:
            rdata_q <= {{(32-`SMCS_EV_W){1'b0}}, en_q};
          `SMCS_CNT_ADDR:
            rdata_q <= {wd_q, rt_q};
          default:
            rdata_q <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- sim/smcs_top_assertions.sv ----
// Port-level assertions for the stop mode clock sequencer.
module smcs_top_assertions #(
  parameter QC_CYCLES = 16
)(
  input wire CLOCK,        // System clock.
  input wire RSTN,         // Reset, active low.
  input wire PSEL,         // APB select.
  input wire PENABLE,      // APB access phase.
  input wire PREADY,       // APB ready.
  input wire PSLVERR,      // APB error.
  input wire EXT_RESET_N,  // External reset, active low.
  input wire OSC_FAIL,     // Monitor failure.
  input wire OTHER_IRQ,    // Other wake interrupt.
  input wire PLL_EN,       // PLL enable.
  input wire VOLTAGE_REGULATOR_EN,      // Regulator enable.
  input wire CORE_CLK_EN,  // Core clock enable.
  input wire SYS_CLK_EN,   // System clock enable.
  input wire PWR_SAVE_REQ, // Power-saving request.
  input wire SELF_CLOCK,   // Self-clock mode.
  input wire STOP_ACTIVE,  // Stop active.
  input wire WAKE,         // Wake pulse.
  input wire SCM_IRQ,      // Self-clock interrupt pulse.
  input wire RESET_REQ     // Reset start pulse.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Run of cycles without monitor failure
  // ------------------------------------------------------------
  int ok_q;
  always @(posedge CLOCK)
  begin
    if (!RSTN || OSC_FAIL)
      ok_q <= 0;
    else if (ok_q < QC_CYCLES)
      ok_q <= ok_q + 1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  stop_entry_a: assert property (
    $rose(STOP_ACTIVE) |-> !CORE_CLK_EN && !SYS_CLK_EN && PWR_SAVE_REQ && (SELF_CLOCK || !PLL_EN))
    else $error("stop entered with clocks on");
  pll_first_a: assert property (
    $fell(CORE_CLK_EN) && !SELF_CLOCK |-> $past(PLL_EN) == 1'b0)
    else $error("core clock off before PLL");
  sys_last_a: assert property (
    $fell(SYS_CLK_EN) |-> $past(CORE_CLK_EN) == 1'b0) else $error("system clock off too early");
  wake_irq_a: assert property (
    STOP_ACTIVE && OTHER_IRQ && !OSC_FAIL && EXT_RESET_N |=> WAKE && !STOP_ACTIVE)
    else $error("interrupt did not end stop");
  scm_power_a: assert property (
    SELF_CLOCK |-> PLL_EN && VOLTAGE_REGULATOR_EN) else $error("self-clock without PLL or regulator");
  ext_reset_a: assert property (
    !EXT_RESET_N |=> RESET_REQ && !STOP_ACTIVE) else $error("external reset not started");
  scm_wake_a: assert property (
    SCM_IRQ |-> SELF_CLOCK && !STOP_ACTIVE ##1 !SCM_IRQ) else $error("self-clock interrupt wrong");
  err_phase_a: assert property (
    PSLVERR |-> PSEL && PENABLE && PREADY) else $error("error outside access phase");
  qc_length_a: assert property (
    $fell(SELF_CLOCK) && EXT_RESET_N && !RESET_REQ |-> ok_q >= QC_CYCLES - 2)
    else $error("quality check passed too soon");
  stop_c: cover property ($rose(STOP_ACTIVE));
  scm_c: cover property (SCM_IRQ);
  rst_c: cover property (RESET_REQ);
endmodule

// ---- sim/smcs_core_model.sv ----
// Core-side model that asks for stop and holds the request until stop is reached.
module smcs_core_model (
  input  wire  clock,           // System clock.
  input  wire  rstn,            // Reset, active low.
  input  wire  go,              // Bench asks the core to stop.
  input  wire  stop_active,     // Stop reached.
  output logic stop_req = 1'b0  // Stop request level.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Dropping the request once stop is active keeps a wake-up from re-entering stop.
  always @(posedge clock)
  begin
    if (!rstn || stop_active)
      stop_req <= 1'b0;
    else if (go)
      stop_req <= 1'b1;
  end
endmodule

// ---- sim/stop_mode_clock_sequencer_test.sv ----
// Self-checking bench for the stop mode clock sequencer.
`include "smcs_defs.vh"
module stop_mode_clock_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam QC = 16;
  logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, last_err;
  logic        wait_mode = 0, ext_n = 1, osc_fail = 0, other_irq = 0, go = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat, c1;
  logic [7:0]  c;
  wire  [31:0] prdata;
  wire         pready, pslverr, stop_req, osc_en, pll_en, voltage_regulator_en, core_en, sys_en, pwr_save;
  wire         self_clk, stop_act, wake, scm_irq, reset_req, cm_vec, irq;
  int          err_total, checks_done, cyc, n, i, m_ctrl, scm_seen, rst_seen, s0;
  logic [7:0]  f_ctrl [5] = '{8'h08, 8'h0B, 8'h0F, 8'h07, 8'h09};
  smcs_top #(.QC_CYCLES(QC)) dut (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .STOP_REQ(stop_req), .WAIT_MODE(wait_mode), .EXT_RESET_N(ext_n),
    .OSC_FAIL(osc_fail), .OTHER_IRQ(other_irq), .OSC_EN(osc_en), .PLL_EN(pll_en),
    .VOLTAGE_REGULATOR_EN(voltage_regulator_en), .CORE_CLK_EN(core_en), .SYS_CLK_EN(sys_en), .PWR_SAVE_REQ(pwr_save),
    .SELF_CLOCK(self_clk), .STOP_ACTIVE(stop_act), .WAKE(wake), .SCM_IRQ(scm_irq),
    .RESET_REQ(reset_req), .CM_VECTOR(cm_vec), .IRQ(irq));
  smcs_core_model core (.clock(clock), .rstn(rstn), .go(go), .stop_active(stop_act),
    .stop_req(stop_req));
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    scm_seen += (scm_irq === 1'b1);
    rst_seen += (reset_req === 1'b1);
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // The request stands until ready is seen at a rising edge; data and error are taken there.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clock);
    if (pready !== 1'b1)
      err_total++;
    last_err = pslverr;
    rdat = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == `SMCS_CTRL_ADDR)
      m_ctrl = (d & 32'h7F) | (m_ctrl & d & 32'h80);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic stop_in();
    go <= 1;
    @(posedge clock);
    for (n = 0; n < 20 && stop_act !== 1'b1; n++) @(posedge clock);
    go <= 0;
    m_ctrl = m_ctrl & 32'hBF;
  endtask
  task automatic wake_up();
    other_irq <= 1;
    @(posedge clock);
    other_irq <= 0;
    repeat (2) @(posedge clock);
    chk(stop_act, 0);
  endtask
  initial
  begin
    void'($urandom(93));
    repeat (2) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    m_ctrl = `SMCS_CTRL_RST;
    rdc(`SMCS_CTRL_ADDR, m_ctrl);
    chk({osc_en, pll_en, voltage_regulator_en, core_en, sys_en}, 5'h17);
    apb(1'b0, 12'h020, 32'hFFFFFFFF);
    chk({last_err, rdat}, {1'b1, 32'h0});
    wr(`SMCS_CTRL_ADDR, 32'h40);
    wr(`SMCS_IRQ_EN_ADDR, 32'h1);
    stop_in();
    chk({osc_en, pll_en, pwr_save}, 3'h1);
    rdc(`SMCS_CTRL_ADDR, m_ctrl);
    apb(1'b0, `SMCS_CNT_ADDR, 32'h0);
    c1 = rdat;
    repeat (10) @(posedge clock);
    rdc(`SMCS_CNT_ADDR, c1);
    apb(1'b0, `SMCS_IRQ_ST_ADDR, 32'h0);
    chk({rdat[0], irq}, 2'h3);
    wr(`SMCS_IRQ_EN_ADDR, 32'h0);
    chk(irq, 0);
    wr(`SMCS_IRQ_EN_ADDR, 32'h1);
    wr(`SMCS_IRQ_CLR_ADDR, 32'h1);
    chk(irq, 0);
    wake_up();
    rdc(`SMCS_CTRL_ADDR, 32'h0);
    wr(`SMCS_CTRL_ADDR, 32'h40);
    rdc(`SMCS_CTRL_ADDR, 32'h40);
    wr(`SMCS_CTRL_ADDR, 32'h38);
    stop_in();
    chk(osc_en, 1);
    apb(1'b0, `SMCS_CNT_ADDR, 32'h0);
    c1 = rdat;
    repeat (10) @(posedge clock);
    apb(1'b0, `SMCS_CNT_ADDR, 32'h0);
    chk({rdat[31:16] != c1[31:16], rdat[15:0] != c1[15:0]}, 2'h3);
    wake_up();
    for (i = 0; i < 5; i++)
    begin
      c = f_ctrl[i];
      wr(`SMCS_CTRL_ADDR, {24'h0, c});
      wait_mode <= (i == 3);
      if (i != 3)
        stop_in();
      s0 = scm_seen;
      osc_fail <= 1;
      repeat (3 + $urandom % 4) @(posedge clock);
      osc_fail <= 0;
      @(posedge clock);
      chk(stop_act, (i != 3) && !(c[0] && (!c[1] || c[2])));
      chk(self_clk, c[0] & c[1]);
      chk(scm_seen - s0, c[0] & c[1] & c[2]);
      if (i == 4)
        chk(cm_vec, 1);
      for (n = 0; n < 100 && self_clk !== 1'b0; n++) @(posedge clock);
      chk(self_clk, 0);
      m_ctrl = (c[0] && !c[1]) ? `SMCS_CTRL_RST : (c[0] ? c | 8'h80 : c);
      rdc(`SMCS_CTRL_ADDR, m_ctrl);
      wr(`SMCS_CTRL_ADDR, m_ctrl & 32'h7F);
      rdc(`SMCS_CTRL_ADDR, m_ctrl);
      if (stop_act === 1'b1)
        wake_up();
      wait_mode <= 0;
    end
    wr(`SMCS_CTRL_ADDR, 32'h08);
    stop_in();
    s0 = rst_seen;
    ext_n <= 0;
    repeat (2) @(posedge clock);
    ext_n <= 1;
    repeat (2) @(posedge clock);
    chk(rst_seen - s0, 32'h2);
    chk({stop_act, cm_vec}, 2'h0);
    rdc(`SMCS_CTRL_ADDR, `SMCS_CTRL_RST);
    end_sim();
  end
endmodule
bind smcs_top smcs_top_assertions #(.QC_CYCLES(QC_CYCLES)) sva (.CLOCK(CLOCK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .OSC_FAIL(OSC_FAIL),
  .EXT_RESET_N(EXT_RESET_N), .OTHER_IRQ(OTHER_IRQ), .PLL_EN(PLL_EN), .VOLTAGE_REGULATOR_EN(VOLTAGE_REGULATOR_EN),
  .CORE_CLK_EN(CORE_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PWR_SAVE_REQ(PWR_SAVE_REQ),
  .SELF_CLOCK(SELF_CLOCK), .STOP_ACTIVE(STOP_ACTIVE), .WAKE(WAKE), .SCM_IRQ(SCM_IRQ),
  .RESET_REQ(RESET_REQ));
